//--- verilog/led_boost_pkg.sv
// Package of timing constants and enumerations for the LED boost control block.
package led_boost_pkg;

  // ********************************************************************
  // Clock rate.
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_PS = 50000;

  // ********************************************************************
  // Printed times and derived cycle counts.
  // ********************************************************************
  localparam int unsigned MAX_ON_TIME_NS   = 4500;
  localparam int unsigned MIN_OFF_TIME_NS  = 400;
  localparam int unsigned BLANK_TIME_NS    = 400;
  localparam int unsigned ENABLE_QUAL_US   = 500;
  localparam int unsigned SHUTDOWN_QUAL_MS = 32;
  localparam int unsigned SHORT_OFF_MS     = 10;

  // Longest times and the shutdown qualifier round down; other least times round up, so never below one cycle.
  localparam int unsigned MAX_ON_CYCLES   = (MAX_ON_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned MIN_OFF_CYCLES  =
    (MIN_OFF_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BLANK_CYCLES    =
    (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ENABLE_CYCLES   =
    (ENABLE_QUAL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SHUTDOWN_CYCLES =
    32'((SHUTDOWN_QUAL_MS * 64'd1000000000) / CLK_PERIOD_PS);

  // ********************************************************************
  // Widths and soft-start figures.
  // ********************************************************************
  localparam int unsigned SHORT_TIMER_W  = 8;
  localparam int unsigned LONG_TIMER_W   = 20;
  localparam int unsigned SOFT_STEP_W    = 8;
  localparam logic [SOFT_STEP_W-1:0] SOFT_STEP_LAST = 8'hFF;

  // Current limit selection to the analog comparator.
  typedef enum logic [1:0] {
    LIMIT_QUARTER = 2'h0,
    LIMIT_HALF    = 2'h1,
    LIMIT_FULL    = 2'h2
  } limit_sel_t;

  typedef enum {
    SW_IDLE,
    SW_ON,
    SW_OFF_WAIT
  } switch_state_t;

endpackage

//--- verilog/input_sync.sv
// Three-stage input synchroniser that reports a level once stages two and three agree.
`timescale 1ns/1ps
module input_sync
  import led_boost_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output logic      level_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;
  logic next_level;

  // ********************************************************************
  // Stable level tracking.
  // ********************************************************************

  // The level only follows when the two later stages agree, filtering one-cycle glitches.
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  // Stage one is read only by stage two, keeping metastability contained.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_out = level;

endmodule // input_sync

//--- verilog/led_boost_pfm_sequencer.sv
// Control logic of a constant-current LED boost converter with PFM switching.
`timescale 1ns/1ps
module led_boost_pfm_sequencer
  import led_boost_pkg::*;
#(
  parameter int unsigned ENABLE_QUAL_CYCLES   = ENABLE_CYCLES,
  parameter int unsigned SHUTDOWN_QUAL_CYCLES = SHUTDOWN_CYCLES
)
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       pwm_ctrl_in,
  input  wire logic       feedback_low_in,
  input  wire logic       switch_current_limit_in,
  input  wire logic       overvoltage_sense_in,
  input  wire logic       supply_lockout_in,
  input  wire logic       over_temp_in,
  output logic            boost_power_switch_out,
  output logic            led_return_switch_out,
  output logic [1:0]      switch_current_limit_sel_out,
  output logic            enabled_out
);

  // ********************************************************************
  // Input synchronisers.
  // ********************************************************************
  logic ctrl_s;
  logic fb_low_s;
  logic switch_current_limit_s;
  logic ovp_s;
  logic supply_lockout_s;
  logic otp_s;

  input_sync u_sync_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(pwm_ctrl_in), .level_out(ctrl_s));
  input_sync u_sync_fb   (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(feedback_low_in), .level_out(fb_low_s));
  input_sync u_sync_switch_current_limit (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(switch_current_limit_in), .level_out(switch_current_limit_s));
  input_sync u_sync_ovp  (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(overvoltage_sense_in), .level_out(ovp_s));
  input_sync u_sync_supply_lockout (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(supply_lockout_in), .level_out(supply_lockout_s));
  input_sync u_sync_otp  (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .async_in(over_temp_in), .level_out(otp_s));

  // A fault forces both switches open regardless of enable.
  logic fault;
  assign fault = supply_lockout_s | otp_s;

  // ********************************************************************
  // Enable and shutdown qualification.
  // ********************************************************************
  logic                    enabled;
  logic                    next_enabled;
  logic [LONG_TIMER_W-1:0] qual_cnt;
  logic [LONG_TIMER_W-1:0] next_qual_cnt;
  logic                    start_soft;

  // One counter measures the current high run while off, or low run while on.
  always_comb begin
    next_enabled  = enabled;
    next_qual_cnt = qual_cnt;
    start_soft    = 1'b0;
    if (!enabled) begin
      if (ctrl_s) begin
        if (qual_cnt >= LONG_TIMER_W'(ENABLE_QUAL_CYCLES - 1)) begin
          next_enabled  = 1'b1;
          next_qual_cnt = '0;
          start_soft    = 1'b1;
        end else begin
          next_qual_cnt = qual_cnt + 1'b1;
        end
      end else begin
        next_qual_cnt = '0;
      end
    end else begin
      // High pulses of any length just restart the low-run count.
      if (ctrl_s) begin
        next_qual_cnt = '0;
      end else if (qual_cnt >= LONG_TIMER_W'(SHUTDOWN_QUAL_CYCLES - 1)) begin
        next_enabled  = 1'b0;
        next_qual_cnt = '0;
      end else begin
        next_qual_cnt = qual_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enabled  <= 1'b0;
      qual_cnt <= '0;
    end else begin
      enabled  <= next_enabled;
      qual_cnt <= next_qual_cnt;
    end
  end

  // ********************************************************************
  // LED return switch and feedback blanking.
  // ********************************************************************
  logic                     led_on;
  logic                     next_led_on;
  logic [SHORT_TIMER_W-1:0] blank_cnt;
  logic [SHORT_TIMER_W-1:0] next_blank_cnt;

  // The switch follows the synchronised control level; a fresh closing starts blanking.
  always_comb begin
    next_led_on    = enabled & ctrl_s & ~fault;
    next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 1'b1 : blank_cnt;
    if (next_led_on && !led_on) begin
      next_blank_cnt = SHORT_TIMER_W'(BLANK_CYCLES);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      led_on    <= 1'b0;
      blank_cnt <= '0;
    end else begin
      led_on    <= next_led_on;
      blank_cnt <= next_blank_cnt;
    end
  end

  // Feedback is trusted only outside the blanking window, and not in the closing cycle either,
  // because the sense voltage seen then still predates the LED switch closing.
  logic fb_valid_low;
  assign fb_valid_low = fb_low_s & (blank_cnt == '0) & ~(next_led_on & ~led_on);

  // ********************************************************************
  // PFM switching sequencer.
  // ********************************************************************
  switch_state_t            sw_state;
  switch_state_t            next_sw_state;
  logic [SHORT_TIMER_W-1:0] sw_cnt;
  logic [SHORT_TIMER_W-1:0] next_sw_cnt;
  logic                     cycle_done;
  logic                     run;

  assign run = enabled & ~fault & ~ovp_s;

  always_comb begin
    next_sw_state = sw_state;
    next_sw_cnt   = sw_cnt + 1'b1;
    cycle_done    = 1'b0;
    unique case (sw_state)
      SW_IDLE: begin
        next_sw_cnt = '0;
        if (run && fb_valid_low) begin
          next_sw_state = SW_ON;
        end
      end
      SW_ON: begin
        // Peak current or the on-time ceiling ends the pulse, whichever first.
        if (!run || switch_current_limit_s ||
            sw_cnt >= SHORT_TIMER_W'(MAX_ON_CYCLES - 1)) begin
          next_sw_state = SW_OFF_WAIT;
          next_sw_cnt   = '0;
          cycle_done    = 1'b1;
        end
      end
      SW_OFF_WAIT: begin
        if (sw_cnt >= SHORT_TIMER_W'(MIN_OFF_CYCLES - 1)) begin
          next_sw_cnt   = sw_cnt;
          next_sw_state = SW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sw_state <= SW_IDLE;
      sw_cnt   <= '0;
    end else begin
      sw_state <= next_sw_state;
      sw_cnt   <= next_sw_cnt;
    end
  end

  // ********************************************************************
  // Soft-start current limit stepping.
  // ********************************************************************
  limit_sel_t             limit;
  limit_sel_t             next_limit;
  logic [SOFT_STEP_W-1:0] step_cnt;
  logic [SOFT_STEP_W-1:0] next_step_cnt;

  // Counting switch cycles, not time, keeps in-rush bounded at any load.
  always_comb begin
    next_limit    = limit;
    next_step_cnt = step_cnt;
    if (start_soft) begin
      next_limit    = LIMIT_QUARTER;
      next_step_cnt = '0;
    end else if (cycle_done && limit != LIMIT_FULL) begin
      if (step_cnt == SOFT_STEP_LAST) begin
        next_step_cnt = '0;
        next_limit    = (limit == LIMIT_QUARTER) ? LIMIT_HALF : LIMIT_FULL;
      end else begin
        next_step_cnt = step_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      limit    <= LIMIT_QUARTER;
      step_cnt <= '0;
    end else begin
      limit    <= next_limit;
      step_cnt <= next_step_cnt;
    end
  end

  // ********************************************************************
  // Outputs.
  // ********************************************************************

  // The fault gate is combinational so a lockout opens the switch without delay.
  assign boost_power_switch_out       = (sw_state == SW_ON) & ~fault;
  assign led_return_switch_out        = led_on;
  assign switch_current_limit_sel_out = limit;
  assign enabled_out                  = enabled;

endmodule // led_boost_pfm_sequencer

//--- dv/host_pwm_model.sv
// Host model that drives the control pin as a plain level or as brightness PWM.
`timescale 1ns/1ps
module host_pwm_model (
  input  wire logic       clk_in,
  input  wire logic       pwm_run_in,
  input  wire logic       level_in,
  input  wire logic [8:0] high_cycles_in,
  output logic            pwm_ctrl_out
);
  // ********************************************************************
  // Pin driver.
  // ********************************************************************
  // A 400 cycle period is 50 kHz, the fastest the device has to accept.
  localparam int unsigned PERIOD = 400;
  int unsigned phase = 0;
  initial pwm_ctrl_out = 1'b0;
  // The pin is driven at all times, so it never floats.
  always @(posedge clk_in) begin
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    pwm_ctrl_out <= #1 pwm_run_in ? (phase < high_cycles_in) : level_in;
  end
endmodule // host_pwm_model

//--- dv/led_boost_checker.sv
// Checker of switch timing, qualification and LED switch at the block ports.
`timescale 1ns/1ps
module led_boost_checker
  import led_boost_pkg::*;
#(
  parameter int unsigned ENABLE_QUAL_CYCLES   = 20,
  parameter int unsigned SHUTDOWN_QUAL_CYCLES = 50
)
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       pwm_ctrl_in,
  input wire logic       feedback_low_in,
  input wire logic       switch_current_limit_in,
  input wire logic       overvoltage_sense_in,
  input wire logic       supply_lockout_in,
  input wire logic       over_temp_in,
  input wire logic       boost_power_switch_out,
  input wire logic       led_return_switch_out,
  input wire logic [1:0] switch_current_limit_sel_out,
  input wire logic       enabled_out
);
  // ********************************************************************
  // Run lengths.
  // ********************************************************************
  int unsigned on_cnt = 0;
  int unsigned hi_cnt = 0;
  int unsigned lo_cnt = 0;
  // Raw pin runs; the design's synchronised runs lag them, and can be longer where a one-cycle glitch is filtered.
  always_ff @(posedge clk_in) begin
    on_cnt <= boost_power_switch_out ? on_cnt + 1 : 0;
    hi_cnt <= pwm_ctrl_in ? hi_cnt + 1 : 0;
    lo_cnt <= pwm_ctrl_in ? 0 : lo_cnt + 1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Six samples cover the four edges of synchronisation and the one of the LED switch register.
  sequence lockout_s; supply_lockout_in [*6]; endsequence
  sequence heat_s; over_temp_in [*6]; endsequence
  sequence led_ok_s;
    (enabled_out && pwm_ctrl_in && !supply_lockout_in && !over_temp_in) [*6];
  endsequence
  max_on_a: assert property (!(boost_power_switch_out && on_cnt >= MAX_ON_CYCLES))
    else $error("power switch on too long");
  min_off_a: assert property ($fell(boost_power_switch_out) |-> !boost_power_switch_out [*8])
    else $error("power switch off time too short");
  peak_off_a: assert property (switch_current_limit_in [*6] |-> !boost_power_switch_out)
    else $error("power switch on past current limit");
  ovp_off_a: assert property (overvoltage_sense_in [*6] |-> !boost_power_switch_out)
    else $error("power switch on during overvoltage");
  lockout_open_a: assert property (lockout_s |-> !boost_power_switch_out && !led_return_switch_out)
    else $error("switch closed during lockout");
  heat_open_a: assert property (heat_s |-> !boost_power_switch_out && !led_return_switch_out)
    else $error("switch closed during over temperature");
  enable_qual_a: assert property ($rose(enabled_out) |-> hi_cnt >= ENABLE_QUAL_CYCLES)
    else $error("enabled without qualified high");
  shut_qual_a: assert property ($fell(enabled_out) && !supply_lockout_in && !over_temp_in
    |-> lo_cnt >= SHUTDOWN_QUAL_CYCLES) else $error("shutdown without qualified low");
  soft_start_a: assert property ($rose(enabled_out) |-> switch_current_limit_sel_out == LIMIT_QUARTER)
    else $error("enable without quarter limit");
  led_follow_a: assert property (led_ok_s |-> led_return_switch_out)
    else $error("led switch open while control high");
  led_off_a: assert property (!enabled_out [*2] |-> !led_return_switch_out)
    else $error("led switch closed in shutdown");
  blank_a: assert property ($rose(led_return_switch_out) |-> (!$rose(boost_power_switch_out)) [*8])
    else $error("switching inside blanking time");
endmodule // led_boost_checker
bind led_boost_pfm_sequencer led_boost_checker #(.ENABLE_QUAL_CYCLES(ENABLE_QUAL_CYCLES),
  .SHUTDOWN_QUAL_CYCLES(SHUTDOWN_QUAL_CYCLES)) chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .pwm_ctrl_in(pwm_ctrl_in), .feedback_low_in(feedback_low_in),
  .switch_current_limit_in(switch_current_limit_in), .overvoltage_sense_in(overvoltage_sense_in),
  .supply_lockout_in(supply_lockout_in), .over_temp_in(over_temp_in),
  .boost_power_switch_out(boost_power_switch_out), .led_return_switch_out(led_return_switch_out),
  .switch_current_limit_sel_out(switch_current_limit_sel_out), .enabled_out(enabled_out));

//--- dv/led_boost_pfm_sequencer_test.sv
// Self-checking bench for the LED boost control block with a host PWM model.
`timescale 1ns/1ps
module led_boost_pfm_sequencer_test;
  import led_boost_pkg::*;
  // ********************************************************************
  // Signals and instances.
  // ********************************************************************
  localparam int unsigned EQ = 20;
  localparam int unsigned SQ = 500;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        run = 1'b0;
  logic        level = 1'b0;
  logic [8:0]  high_cyc = 9'h004;
  logic [3:0]  hold = 4'h8; // Feedback high, heat, lockout, overvoltage.
  logic        switch_current_limit = 1'b0;
  logic        switch_current_limit_on = 1'b1;
  logic        ctrl, boost, led, en;
  logic        prev_en = 1'b0;
  logic [1:0]  sel;
  logic [1:0]  prev_sel = 2'h0;
  int unsigned error_cnt = 0, tests_run = 0, pulses = 0, len;
  logic        en_q[$];
  logic [1:0]  sel_q[$];
  int unsigned cnt_q[$];
  host_pwm_model host_u (.clk_in(clk_in), .pwm_run_in(run), .level_in(level),
    .high_cycles_in(high_cyc), .pwm_ctrl_out(ctrl));
  led_boost_pfm_sequencer #(.ENABLE_QUAL_CYCLES(EQ), .SHUTDOWN_QUAL_CYCLES(SQ)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pwm_ctrl_in(ctrl), .feedback_low_in(!hold[3]),
    .switch_current_limit_in(switch_current_limit), .overvoltage_sense_in(hold[0]),
    .supply_lockout_in(hold[1]), .over_temp_in(hold[2]), .boost_power_switch_out(boost),
    .led_return_switch_out(led), .switch_current_limit_sel_out(sel), .enabled_out(en));
  initial forever #25 clk_in = ~clk_in;
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic check_sel(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int unsigned got, input int unsigned exp);
    tests_run++;
    if (got != exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ********************************************************************
  // Watchers and responders.
  // ********************************************************************
  // Each enable change, and each limit change with the block enabled before and after, takes the oldest note kept for it.
  always @(posedge clk_in) begin
    #2;
    if (en !== prev_en) begin
      check_bit(en, en_q.size() ? en_q.pop_front() : !en);
      if (en) check_sel(sel, LIMIT_QUARTER);
    end
    if (en && prev_en && sel !== prev_sel) begin
      check_sel(sel, sel_q.size() ? sel_q.pop_front() : ~sel);
      check_cnt(pulses, cnt_q.size() ? cnt_q.pop_front() : 0);
    end
    prev_en = en;
    prev_sel = sel;
  end
  // The limit trips a random few cycles into each on-time, as a current ramp would.
  always @(posedge boost) if (switch_current_limit_on) begin
    repeat ($urandom_range(12, 2)) @(posedge clk_in);
    #1 switch_current_limit = 1'b1;
    while (boost) @(posedge clk_in);
    #1 switch_current_limit = 1'b0;
  end
  always @(negedge boost) pulses++;
  // The run is near 20000 cycles; three times that can only be a hang.
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    end_of_test;
  end
  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial begin
    void'($urandom(32'hC02BE2E9));
    tick(6);
    sys_rst_in = 1'b0;
    check_bit(en, 1'b0);
    check_sel(sel, LIMIT_QUARTER);
    // A high pulse shorter than the qualifier must be ignored.
    level = 1'b1;
    tick(EQ - 4);
    level = 1'b0;
    tick(20);
    check_bit(en, 1'b0);
    hold = 4'h0;
    en_q.push_back(1'b1);
    sel_q = '{LIMIT_HALF, LIMIT_FULL};
    cnt_q = '{256, 512};
    level = 1'b1;
    for (int i = 0; i < 40000 && sel !== LIMIT_FULL; i++) tick(1);
    check_sel(sel, LIMIT_FULL);
    // Without a current trip the on-time stops at its maximum.
    switch_current_limit_on = 1'b0;
    @(posedge boost);
    len = 0;
    while (boost) begin
      tick(1);
      len++;
    end
    check_cnt(len, MAX_ON_CYCLES);
    switch_current_limit_on = 1'b1;
    // Each fault, and feedback above reference, keeps the power switch off.
    for (int k = 0; k < 4; k++) begin
      hold = 4'(1 << k);
      tick(30);
      len = 0;
      repeat (40) begin
        tick(1);
        if (boost) len++;
      end
      check_cnt(len, 0);
      check_bit(led, k == 0 || k == 3);
      hold = 4'h0;
      for (len = 0; len < 200 && !boost; len++) tick(1);
      check_bit(boost, 1'b1);
    end
    // Short and random PWM pulses pass without leaving the enabled state.
    for (int k = 0; k < 2; k++) begin
      high_cyc = k ? 9'($urandom_range(396, 4)) : 9'h004;
      run = 1'b1;
      tick(3200);
    end
    check_bit(en, 1'b1);
    run = 1'b0;
    level = 1'b0;
    en_q.push_back(1'b0);
    tick(SQ + 20);
    check_bit(led, 1'b0);
    en_q.push_back(1'b1);
    level = 1'b1;
    tick(EQ + 20);
    end_of_test;
  end
endmodule // led_boost_pfm_sequencer_test
